// File: spc_pkg.sv
// Shared constants for the switch port control block
package spc_pkg;

	// ==========================================================
	// Sizes
	localparam int SPC_PORTS = 8;
	localparam int N_CNT     = 9;
	localparam int CNT_W     = 32;
	localparam int ADDR_W    = 10;
	localparam int DATA_W    = 32;
	localparam int LEN_W     = 11;
	localparam int CFG_W     = 7;
	localparam int ST_W      = 6;
	localparam int IRQ_W     = 2 * SPC_PORTS;

	// ==========================================================
	// Register map
	localparam int GLB_BIT  = 9;
	localparam int PORT_SH  = 6;
	localparam int PSEL_W   = 3;
	localparam int OFF_W    = 6;
	localparam logic [OFF_W-1:0]  OFF_CFG     = 6'h00;
	localparam logic [OFF_W-1:0]  OFF_ACT     = 6'h04;
	localparam logic [OFF_W-1:0]  OFF_STAT    = 6'h08;
	localparam logic [OFF_W-1:0]  OFF_CNT0    = 6'h10;
	localparam logic [OFF_W-1:0]  OFF_CNTL    = 6'h30;
	localparam logic [ADDR_W-1:0] OFF_APPLY   = 10'h200;
	localparam logic [ADDR_W-1:0] OFF_CLEAR   = 10'h204;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 10'h208;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 10'h20C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 10'h210;
	localparam logic [ADDR_W-1:0] OFF_PAUSE   = 10'h214;

	// ==========================================================
	// Port configuration fields
	localparam int CFG_EN    = 0;
	localparam int CFG_FORCE = 1;
	localparam int CFG_SPD   = 2;
	localparam int CFG_DUP   = 4;
	localparam int CFG_FLOW  = 5;
	localparam int CFG_SEC   = 6;
	localparam logic [CFG_W-1:0] CFG_RST = 7'h39;
	localparam logic [1:0] SPD_10  = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1G  = 2'h2;

	// ==========================================================
	// Port status fields
	localparam int ST_LINK = 0;
	localparam int ST_SPD  = 1;
	localparam int ST_DUP  = 3;
	localparam int ST_FLOW = 4;
	localparam int ST_NA   = 5;

	// ==========================================================
	// Counter indices
	localparam int C_TX_GOOD = 0;
	localparam int C_TX_BAD  = 1;
	localparam int C_RX_GOOD = 2;
	localparam int C_RX_BAD  = 3;
	localparam int C_TX_ABRT = 4;
	localparam int C_COLL    = 5;
	localparam int C_DROP    = 6;
	localparam int C_BCAST   = 7;
	localparam int C_MCAST   = 8;

	// ==========================================================
	// Frame limits and pause
	localparam logic [LEN_W-1:0] MIN_FRAME = 11'h040;
	localparam logic [LEN_W-1:0] MAX_FRAME = 11'h5EE;
	localparam logic [15:0]      PAUSE_RST = 16'hFFFF;

endpackage : spc_pkg

// File: spc_cnt_if.sv
// Counter bank request and read-back bundle
`timescale 1ns/1ps
interface spc_cnt_if;
	import spc_pkg::*;
	logic [N_CNT-1:0] inc;
	logic             clr;
	logic [3:0]       sel;
	logic [CNT_W-1:0] value;
	modport bank (input inc, input clr, input sel, output value);
	modport user (output inc, output clr, output sel, input value);
endinterface : spc_cnt_if

// File: spc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module spc_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			dout   <= '0;
		end else if (clk_en) begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule : spc_sync

// File: spc_cnt_bank.sv
// Per-port bank of frame statistics counters
`timescale 1ns/1ps
module spc_cnt_bank
	import spc_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	spc_cnt_if.bank   bus
);
	logic [CNT_W-1:0] cnt_r [N_CNT];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Counters
	for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				cnt_r[i] <= '0;
			end else if (clk_en) begin
				if (bus.clr) begin
					cnt_r[i] <= '0;
				end else if (bus.inc[i]) begin
					cnt_r[i] <= cnt_r[i] + 1'b1;
				end
			end
		end
	end

	assign bus.value = (bus.sel < 4'(N_CNT)) ? cnt_r[bus.sel] : '0;

	// ==========================================================
	// Checks
	a_cnt_clear: assert property (
		(clk_en && bus.clr) |=> (cnt_r[0] == '0 && cnt_r[N_CNT-1] == '0))
		else $error("counter not zeroed by clear");
	a_cnt_step: assert property (
		(clk_en && !bus.clr && bus.inc[C_RX_GOOD])
		|=> cnt_r[C_RX_GOOD] == $past(cnt_r[C_RX_GOOD]) + 1'b1)
		else $error("counter did not step by one");
endmodule : spc_cnt_bank

// File: spc_top.sv
// Per-port control, status, security and statistics of the switch
// Functional notes
// - A disabled port neither accepts received frames nor transmits.
// - In automatic mode speed and duplex come from auto-negotiation.
// - In forced mode the port runs at the management speed and duplex.
// - Speed and duplex are writable only while forced mode is chosen.
// - With flow control on, overload sends a PAUSE request to the sender.
// - With flow control off, frames that cannot be taken are discarded.
// - With security on, frames from unknown source addresses are blocked.
// - New settings take effect only when an apply action commits them; here the pause time and interrupt enables take effect on write.
// - Per-port frame counters exist and a clear command zeroes them all.
// - Short, long, fragment, jabber, CRC or alignment frames count bad.
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module spc_top
	import spc_pkg::*;
(
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         clk_en,
	input  wire logic [ADDR_W-1:0]            reg_addr,
	input  wire logic [DATA_W-1:0]            reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [DATA_W-1:0]            reg_rdata,
	output logic                              irq,
	input  wire logic [SPC_PORTS-1:0]         phy_link,
	input  wire logic [2*SPC_PORTS-1:0]       phy_an_speed,
	input  wire logic [SPC_PORTS-1:0]         phy_an_duplex,
	output logic      [SPC_PORTS-1:0]         phy_an_enable,
	output logic      [2*SPC_PORTS-1:0]       phy_force_speed,
	output logic      [SPC_PORTS-1:0]         phy_force_duplex,
	input  wire logic [SPC_PORTS-1:0]         rx_eof,
	input  wire logic [SPC_PORTS*LEN_W-1:0]   rx_len,
	input  wire logic [SPC_PORTS-1:0]         rx_crc_err,
	input  wire logic [SPC_PORTS-1:0]         rx_align_err,
	input  wire logic [SPC_PORTS-1:0]         rx_bcast,
	input  wire logic [SPC_PORTS-1:0]         rx_mcast,
	input  wire logic [SPC_PORTS-1:0]         rx_sa_known,
	input  wire logic [SPC_PORTS-1:0]         rx_overload,
	output logic      [SPC_PORTS-1:0]         rx_accept,
	output logic      [SPC_PORTS-1:0]         rx_discard,
	input  wire logic [SPC_PORTS-1:0]         tx_req,
	input  wire logic [SPC_PORTS-1:0]         tx_eof,
	input  wire logic [SPC_PORTS*LEN_W-1:0]   tx_len,
	input  wire logic [SPC_PORTS-1:0]         tx_crc_err,
	input  wire logic [SPC_PORTS-1:0]         tx_abort,
	input  wire logic [SPC_PORTS-1:0]         tx_collision,
	output logic      [SPC_PORTS-1:0]         tx_grant,
	output logic      [SPC_PORTS-1:0]         pause_send,
	output logic      [15:0]                  pause_quanta
);
	localparam int SYNC_W = 4 * SPC_PORTS;

	logic [CFG_W-1:0]     cfg_r [SPC_PORTS];
	logic [CFG_W-1:0]     act_r [SPC_PORTS];
	logic [ST_W-1:0]      stat_w [SPC_PORTS];
	logic [CNT_W-1:0]     cnt_val [SPC_PORTS];
	logic [SYNC_W-1:0]    sync_q;
	logic [SPC_PORTS-1:0] lnk_s;
	logic [SPC_PORTS-1:0] dup_s;
	logic [SPC_PORTS-1:0] lnk_q_r;
	logic [SPC_PORTS-1:0] ovl_q_r;
	logic [SPC_PORTS-1:0] apply_p;
	logic [SPC_PORTS-1:0] sec_ev;
	logic [IRQ_W-1:0]     irq_st_r;
	logic [IRQ_W-1:0]     irq_en_r;
	logic [IRQ_W-1:0]     irq_ev;
	logic [IRQ_W-1:0]     irq_clr;
	logic [DATA_W-1:0]    rd_nxt;
	logic                 wr_en;
	logic                 cnt_clr;
	logic                 glb;
	logic [PSEL_W-1:0]    psel;
	logic [OFF_W-1:0]     off;
	logic [3:0]           cnt_sel;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Bus decode
	// Strobes seen while the clock enable is low are lost
	assign wr_en   = reg_wr && clk_en;
	assign glb     = reg_addr[GLB_BIT];
	assign psel    = reg_addr[PORT_SH +: PSEL_W];
	assign off     = reg_addr[OFF_W-1:0];
	assign cnt_sel = 4'((off - OFF_CNT0) >> 2);
	assign cnt_clr = wr_en && reg_addr == OFF_CLEAR;
	assign irq_clr = (wr_en && reg_addr == OFF_IRQ_CLR) ?
		reg_wdata[IRQ_W-1:0] : '0;

	// ==========================================================
	// Pin synchronisers
	spc_sync #(.W(SYNC_W)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.din     ({phy_an_duplex, phy_an_speed, phy_link}),
		.dout    (sync_q)
	);
	assign lnk_s = sync_q[SPC_PORTS-1:0];
	assign dup_s = sync_q[SYNC_W-1 -: SPC_PORTS];

	// ==========================================================
	// Per-port logic
	for (genvar p = 0; p < SPC_PORTS; p++) begin : g_port
		spc_cnt_if cif ();
		logic [LEN_W-1:0] rlen;
		logic [LEN_W-1:0] tlen;
		logic [1:0]       an_spd;
		logic             en;
		logic             live;
		logic             flow;
		logic             rx_bad;
		logic             tx_bad;
		logic             sec_blk;
		logic             ovl_drop;
		logic             take;

		assign rlen   = rx_len[p*LEN_W +: LEN_W];
		assign tlen   = tx_len[p*LEN_W +: LEN_W];
		assign an_spd = sync_q[SPC_PORTS+2*p +: 2];
		assign en     = act_r[p][CFG_EN];
		assign live   = en && lnk_s[p];
		assign flow   = act_r[p][CFG_FLOW];
		assign apply_p[p] = wr_en && reg_addr == OFF_APPLY && reg_wdata[p];

		// Fragments and jabbers show as a length fault plus CRC error
		assign rx_bad = rlen < MIN_FRAME || rlen > MAX_FRAME ||
			rx_crc_err[p] || rx_align_err[p];
		assign tx_bad = tlen < MIN_FRAME || tlen > MAX_FRAME ||
			tx_crc_err[p];
		assign sec_blk  = act_r[p][CFG_SEC] && !rx_sa_known[p];
		assign ovl_drop = !flow && rx_overload[p];
		assign take = live && !rx_bad && !sec_blk && !ovl_drop;
		assign sec_ev[p] = clk_en && rx_eof[p] && live && sec_blk;

		// Staged settings; speed and duplex only move in forced mode
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				cfg_r[p] <= CFG_RST;
			end else if (wr_en && !glb && psel == PSEL_W'(p) &&
				off == OFF_CFG) begin
				cfg_r[p][CFG_EN]    <= reg_wdata[CFG_EN];
				cfg_r[p][CFG_FORCE] <= reg_wdata[CFG_FORCE];
				cfg_r[p][CFG_FLOW]  <= reg_wdata[CFG_FLOW];
				cfg_r[p][CFG_SEC]   <= reg_wdata[CFG_SEC];
				if (reg_wdata[CFG_FORCE]) begin
					cfg_r[p][CFG_SPD +: 2] <= reg_wdata[CFG_SPD +: 2];
					cfg_r[p][CFG_DUP]      <= reg_wdata[CFG_DUP];
				end
			end
		end

		always_ff @(posedge sys_clk) begin
			if (rst) begin
				act_r[p] <= CFG_RST;
			end else if (apply_p[p]) begin
				act_r[p] <= cfg_r[p];
			end
		end

		// Resolved mode towards the PHY
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				phy_an_enable[p]         <= 1'b0;
				phy_force_speed[2*p +: 2] <= SPD_1G;
				phy_force_duplex[p]      <= 1'b1;
			end else if (clk_en) begin
				phy_an_enable[p] <= en && !act_r[p][CFG_FORCE];
				phy_force_speed[2*p +: 2] <= act_r[p][CFG_SPD +: 2];
				phy_force_duplex[p] <= act_r[p][CFG_DUP];
			end
		end

		// Actual status; configured values stay untouched
		always_comb begin
			stat_w[p] = '0;
			stat_w[p][ST_LINK] = lnk_s[p];
			if (!lnk_s[p]) begin
				stat_w[p][ST_NA] = 1'b1;
			end else if (act_r[p][CFG_FORCE]) begin
				stat_w[p][ST_SPD +: 2] = act_r[p][CFG_SPD +: 2];
				stat_w[p][ST_DUP]      = act_r[p][CFG_DUP];
				stat_w[p][ST_FLOW]     = flow;
			end else begin
				stat_w[p][ST_SPD +: 2] = an_spd;
				stat_w[p][ST_DUP]      = dup_s[p];
				stat_w[p][ST_FLOW]     = flow;
			end
		end

		// Frame decisions and flow control
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				rx_accept[p]  <= 1'b0;
				rx_discard[p] <= 1'b0;
				tx_grant[p]   <= 1'b0;
				pause_send[p] <= 1'b0;
				ovl_q_r[p]    <= 1'b0;
				lnk_q_r[p]    <= 1'b0;
			end else if (clk_en) begin
				rx_accept[p]  <= rx_eof[p] && take;
				rx_discard[p] <= rx_eof[p] && !take;
				tx_grant[p]   <= tx_req[p] && live;
				pause_send[p] <= live && flow && rx_overload[p] &&
					!ovl_q_r[p];
				ovl_q_r[p]    <= rx_overload[p];
				lnk_q_r[p]    <= lnk_s[p];
			end
		end

		// Statistics; a disabled port counts nothing
		always_comb begin
			cif.inc = '0;
			cif.inc[C_TX_GOOD] = tx_eof[p] && live && !tx_bad;
			cif.inc[C_TX_BAD]  = tx_eof[p] && live && tx_bad;
			cif.inc[C_RX_GOOD] = rx_eof[p] && live && !rx_bad;
			cif.inc[C_RX_BAD]  = rx_eof[p] && live && rx_bad;
			cif.inc[C_TX_ABRT] = tx_abort[p] && live;
			cif.inc[C_COLL]    = tx_collision[p] && live;
			cif.inc[C_DROP]    = rx_eof[p] && live && !rx_bad &&
				(sec_blk || ovl_drop);
			cif.inc[C_BCAST]   = rx_eof[p] && take && rx_bcast[p];
			cif.inc[C_MCAST]   = rx_eof[p] && take && rx_mcast[p];
		end
		assign cif.clr    = cnt_clr;
		assign cif.sel    = cnt_sel;
		assign cnt_val[p] = cif.value;

		spc_cnt_bank u_bank (
			.sys_clk (sys_clk),
			.rst     (rst),
			.clk_en  (clk_en),
			.bus     (cif.bank)
		);

		// ======================================================
		// Checks
		sequence s_ovl_rise;
			clk_en && live && flow && rx_overload[p] && !ovl_q_r[p];
		endsequence
		sequence s_pause_out;
			pause_send[p] ##1 (!$past(clk_en) || !pause_send[p]);
		endsequence

		a_dis_no_rx: assert property (
			(clk_en && !en) |=> !rx_accept[p])
			else $error("disabled port accepted a frame");
		a_dis_no_tx: assert property (
			(clk_en && !en) |=> !tx_grant[p])
			else $error("disabled port granted transmit");
		a_auto_neg_on: assert property (
			(clk_en && en && !act_r[p][CFG_FORCE]) |=> phy_an_enable[p])
			else $error("auto mode without negotiation");
		a_forced_mode: assert property (
			(clk_en && act_r[p][CFG_FORCE]) |=> (!phy_an_enable[p] &&
			phy_force_speed[2*p +: 2] == $past(act_r[p][CFG_SPD +: 2])))
			else $error("forced speed not driven");
		a_ro_in_auto: assert property (
			(wr_en && !glb && psel == PSEL_W'(p) && off == OFF_CFG &&
			!reg_wdata[CFG_FORCE]) |=> $stable(cfg_r[p][CFG_SPD +: 2]))
			else $error("speed written in auto mode");
		a_pause_req: assert property (
			s_ovl_rise |=> s_pause_out)
			else $error("overload did not send one pause");
		a_drop_noflow: assert property (
			(clk_en && rx_eof[p] && !flow && rx_overload[p])
			|=> (rx_discard[p] && !rx_accept[p]))
			else $error("overloaded frame not discarded");
		a_sec_block: assert property (
			(clk_en && rx_eof[p] && act_r[p][CFG_SEC] && !rx_sa_known[p])
			|=> !rx_accept[p] ##0 rx_discard[p])
			else $error("unknown source address passed");
		a_apply_hold: assert property (
			!apply_p[p] |=> $stable(act_r[p]))
			else $error("settings changed without apply");
		a_apply_take: assert property (
			apply_p[p] |=> act_r[p] == $past(cfg_r[p]))
			else $error("apply did not commit settings");
		a_short_bad: assert property (
			(clk_en && rx_eof[p] && rlen < MIN_FRAME) |=> !rx_accept[p])
			else $error("undersize frame accepted");
		a_link_na: assert property (
			!lnk_s[p] |-> (stat_w[p][ST_NA] && stat_w[p][ST_SPD +: 2] == '0
			&& !stat_w[p][ST_FLOW]))
			else $error("status shown while link down");
	end

	// ==========================================================
	// Interrupts
	assign irq_ev = {sec_ev, clk_en ? (lnk_s ^ lnk_q_r) : '0};

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_st_r <= '0;
		end else begin
			// A new event beats a clear in the same cycle
			irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_en_r     <= '0;
			pause_quanta <= PAUSE_RST;
		end else if (wr_en && reg_addr == OFF_IRQ_EN) begin
			irq_en_r <= reg_wdata[IRQ_W-1:0];
		end else if (wr_en && reg_addr == OFF_PAUSE) begin
			pause_quanta <= reg_wdata[15:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(irq_st_r & irq_en_r);
		end
	end

	// ==========================================================
	// Read-back
	always_comb begin
		rd_nxt = '0;
		if (glb) begin
			case (reg_addr)
				OFF_IRQ_ST: rd_nxt[IRQ_W-1:0] = irq_st_r;
				OFF_IRQ_EN: rd_nxt[IRQ_W-1:0] = irq_en_r;
				OFF_PAUSE:  rd_nxt[15:0]      = pause_quanta;
				default:    rd_nxt = '0;
			endcase
		end else if (off == OFF_CFG) begin
			rd_nxt[CFG_W-1:0] = cfg_r[psel];
		end else if (off == OFF_ACT) begin
			rd_nxt[CFG_W-1:0] = act_r[psel];
		end else if (off == OFF_STAT) begin
			rd_nxt[ST_W-1:0] = stat_w[psel];
		end else if (off >= OFF_CNT0 && off <= OFF_CNTL &&
			off[1:0] == 2'h0) begin
			rd_nxt = cnt_val[psel];
		end
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? rd_nxt : '0;
		end
	end

	a_irq_level: assert property (
		(clk_en && |(irq_st_r & irq_en_r)) |=> irq)
		else $error("enabled status without interrupt");
endmodule : spc_top

// File: spc_link_partner.sv
// Remote link partner model driving link state and received frames
`timescale 1ns/1ps
module spc_link_partner
	import spc_pkg::*;
(
	input  wire logic                       sys_clk,
	output logic      [SPC_PORTS-1:0]       phy_link,
	output logic      [2*SPC_PORTS-1:0]     phy_an_speed,
	output logic      [SPC_PORTS-1:0]       phy_an_duplex,
	output logic      [SPC_PORTS-1:0]       rx_eof,
	output logic      [SPC_PORTS*LEN_W-1:0] rx_len,
	output logic      [SPC_PORTS-1:0]       rx_crc_err,
	output logic      [SPC_PORTS-1:0]       rx_align_err,
	output logic      [SPC_PORTS-1:0]       rx_bcast,
	output logic      [SPC_PORTS-1:0]       rx_mcast,
	output logic      [SPC_PORTS-1:0]       rx_sa_known,
	input  wire logic [SPC_PORTS-1:0]       pause_send
);
	int pause_seen = 0;

	initial begin
		{phy_link, phy_an_speed, phy_an_duplex, rx_eof} = '0;
		{rx_len, rx_crc_err, rx_align_err} = '0;
		{rx_bcast, rx_mcast, rx_sa_known} = '0;
	end

	// ==========================================================
	// Pause monitor
	// Counts every high cycle, so a stretched pulse shows up
	always @(posedge sys_clk) begin
		if (pause_send !== '0) begin
			pause_seen++;
		end
	end

	// ==========================================================
	// Link and frame tasks
	task automatic link_set(input int p, input logic up,
		input logic [1:0] spd, input logic dup);
		@(posedge sys_clk);
		phy_link[p] <= up;
		phy_an_speed[2*p +: 2] <= spd;
		phy_an_duplex[p] <= dup;
	endtask : link_set

	// fl holds {known source, multicast, broadcast, align, crc}
	task automatic send(input int p, input logic [LEN_W-1:0] len,
		input logic [4:0] fl);
		@(posedge sys_clk);
		rx_eof[p] <= 1'b1;
		rx_len[LEN_W*p +: LEN_W] <= len;
		{rx_sa_known[p], rx_mcast[p], rx_bcast[p], rx_align_err[p],
			rx_crc_err[p]} <= fl;
		@(posedge sys_clk);
		rx_eof[p] <= 1'b0;
		// Attributes mean nothing outside the end pulse
		rx_len <= ~rx_len;
		{rx_sa_known[p], rx_mcast[p], rx_bcast[p], rx_align_err[p],
			rx_crc_err[p]} <= ~fl;
	endtask : send

endmodule : spc_link_partner

// File: spc_top_tb.sv
// Self-checking bench for the switch port control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("[FAIL] %s exp %0h got %0h", nm, e, g); \
	end \
end
module spc_top_tb
	import spc_pkg::*;
;
	logic                       sys_clk, rst, clk_en, reg_wr, reg_rd, irq;
	logic [ADDR_W-1:0]          reg_addr;
	logic [DATA_W-1:0]          reg_wdata, reg_rdata;
	logic [SPC_PORTS-1:0]       phy_link, phy_an_duplex, phy_an_enable;
	logic [SPC_PORTS-1:0]       phy_force_duplex, rx_eof, rx_crc_err;
	logic [SPC_PORTS-1:0]       rx_align_err, rx_bcast, rx_mcast, rx_sa_known;
	logic [SPC_PORTS-1:0]       rx_overload, rx_accept, rx_discard, tx_req;
	logic [SPC_PORTS-1:0]       tx_eof, tx_crc_err, tx_abort, tx_collision;
	logic [SPC_PORTS-1:0]       tx_grant, pause_send;
	logic [2*SPC_PORTS-1:0]     phy_an_speed, phy_force_speed;
	logic [SPC_PORTS*LEN_W-1:0] rx_len, tx_len;
	logic [15:0]                pause_quanta;
	logic [CNT_W-1:0]           e [N_CNT];
	int                         bad_count = 0;
	int                         cmp_count = 0;

	spc_top i_dut (
		.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .phy_link, .phy_an_speed, .phy_an_duplex,
		.phy_an_enable, .phy_force_speed, .phy_force_duplex, .rx_eof,
		.rx_len, .rx_crc_err, .rx_align_err, .rx_bcast, .rx_mcast,
		.rx_sa_known, .rx_overload, .rx_accept, .rx_discard, .tx_req,
		.tx_eof, .tx_len, .tx_crc_err, .tx_abort, .tx_collision, .tx_grant,
		.pause_send, .pause_quanta
	);

	spc_link_partner i_lp (
		.sys_clk, .phy_link, .phy_an_speed, .phy_an_duplex, .rx_eof,
		.rx_len, .rx_crc_err, .rx_align_err, .rx_bcast, .rx_mcast,
		.rx_sa_known, .pause_send
	);

	// ==========================================================
	// Bus and stimulus tasks
	function automatic logic [ADDR_W-1:0] pa(input int p,
		input logic [OFF_W-1:0] o);
		return ADDR_W'(p << PORT_SH) | ADDR_W'(o);
	endfunction : pa

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] x);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(nm, x, reg_rdata)
	endtask : rd_chk

	task automatic apply(input logic [DATA_W-1:0] cfg);
		wr(pa(0, OFF_CFG), cfg);
		wr(OFF_APPLY, 32'h1);
		repeat (3) @(posedge sys_clk);
	endtask : apply

	task automatic frm(input logic [LEN_W-1:0] len, input logic [4:0] fl,
		input logic acc);
		i_lp.send(0, len, fl);
		#1;
		`CHK("rx verdict", {acc, ~acc}, {rx_accept[0], rx_discard[0]})
	endtask : frm

	// k holds {collision, abort, crc, end of frame}
	task automatic tx_pulse(input logic [3:0] k);
		@(posedge sys_clk);
		{tx_collision[0], tx_abort[0], tx_crc_err[0], tx_eof[0]} <= k;
		tx_len[LEN_W-1:0] <= 11'h064;
		@(posedge sys_clk);
		{tx_collision[0], tx_abort[0], tx_crc_err[0], tx_eof[0]} <= 4'h0;
	endtask : tx_pulse

	task automatic chk_cnt;
		for (int i = 0; i < N_CNT; i++) begin
			rd_chk("counter", pa(0, OFF_CNT0 + OFF_W'(4*i)), e[i]);
		end
	endtask : chk_cnt

	task automatic tend(input string nm);
		$display("test %s finished", nm);
	endtask : tend

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// Clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// The whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count++;
		summarize();
	end

	// ==========================================================
	// Test sequence
	initial begin
		logic [LEN_W-1:0] lens [7];
		logic [4:0]       fls [7];
		logic [6:0]       acc;
		lens = '{11'd100, 11'd64, 11'd1518, 11'd63, 11'd1519, 11'd100, 11'd100};
		fls = '{5'h14, 5'h18, 5'h10, 5'h10, 5'h10, 5'h12, 5'h11};
		acc = 7'b1110000;
		e = '{default: '0};
		{rst, clk_en} = 2'b11;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{rx_overload, tx_req, tx_eof, tx_len} = '0;
		{tx_crc_err, tx_abort, tx_collision} = '0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd_chk("staged cfg", pa(0, OFF_CFG), 32'h39);
		rd_chk("active cfg", pa(0, OFF_ACT), 32'h39);
		rd_chk("status down", pa(0, OFF_STAT), 32'h20);
		rd_chk("unmapped", pa(0, 6'h34), 32'h0);
		`CHK("force speed", {SPC_PORTS{SPD_1G}}, phy_force_speed)
		tend("reset");

		i_lp.link_set(0, 1'b1, SPD_100, 1'b0);
		repeat (6) @(posedge sys_clk);
		rd_chk("status auto", pa(0, OFF_STAT), 32'h13);
		`CHK("an enable", 1'b1, phy_an_enable[0])
		wr(pa(0, OFF_CFG), 32'h21);
		rd_chk("speed locked", pa(0, OFF_CFG), 32'h39);
		tend("auto");

		wr(pa(0, OFF_CFG), 32'h33);
		rd_chk("staged forced", pa(0, OFF_CFG), 32'h33);
		rd_chk("active held", pa(0, OFF_ACT), 32'h39);
		`CHK("no early force", 1'b1, phy_an_enable[0])
		apply(32'h33);
		rd_chk("active forced", pa(0, OFF_ACT), 32'h33);
		rd_chk("status forced", pa(0, OFF_STAT), 32'h19);
		`CHK("force pins", 4'h4, {phy_an_enable[0], phy_force_duplex[0],
			phy_force_speed[1:0]})
		tend("forced");

		for (int i = 0; i < 7; i++) begin
			frm(lens[i], fls[i], acc[6-i]);
		end
		e[C_RX_GOOD] = 3;
		e[C_RX_BAD] = 4;
		e[C_BCAST] = 1;
		e[C_MCAST] = 1;
		tend("frame classes");

		wr(OFF_PAUSE, 32'h1234);
		rd_chk("pause reg", OFF_PAUSE, 32'h1234);
		rx_overload[0] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		`CHK("pause sent", 1, i_lp.pause_seen)
		`CHK("pause time", 16'h1234, pause_quanta)
		rx_overload[0] <= 1'b0;
		apply(32'h13);
		rx_overload[0] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		`CHK("no pause", 1, i_lp.pause_seen)
		frm(11'd100, 5'h10, 1'b0);
		rx_overload[0] <= 1'b0;
		tend("flow control");

		apply(32'h73);
		wr(OFF_IRQ_EN, 32'h100);
		frm(11'd100, 5'h00, 1'b0);
		rd_chk("irq status", OFF_IRQ_ST, 32'h101);
		`CHK("irq up", 1'b1, irq)
		wr(OFF_IRQ_CLR, 32'h100);
		repeat (2) @(posedge sys_clk);
		`CHK("irq down", 1'b0, irq)
		frm(11'd100, 5'h10, 1'b1);
		e[C_DROP] = 2;
		// Good frames dropped for overload or security still count good
		e[C_RX_GOOD] = 6;
		tend("security");

		tx_req[0] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK("grant", 1'b1, tx_grant[0])
		tx_pulse(4'h1);
		tx_pulse(4'h3);
		tx_pulse(4'h4);
		tx_pulse(4'h8);
		{e[C_TX_GOOD], e[C_TX_BAD], e[C_TX_ABRT], e[C_COLL]} = {4{32'h1}};
		apply(32'h32);
		frm(11'd100, 5'h10, 1'b0);
		`CHK("no grant", 1'b0, tx_grant[0])
		tx_pulse(4'h1);
		tx_req[0] <= 1'b0;
		chk_cnt();
		tend("transmit and disable");

		wr(OFF_CLEAR, 32'h1);
		e = '{default: '0};
		chk_cnt();
		i_lp.link_set(0, 1'b0, SPD_1G, 1'b1);
		repeat (6) @(posedge sys_clk);
		rd_chk("status lost", pa(0, OFF_STAT), 32'h20);
		rd_chk("cfg kept", pa(0, OFF_ACT), 32'h32);
		tend("clear and link loss");
		summarize();
	end

endmodule : spc_top_tb
